// ### core/pin_sync.v
// Two-stage synchroniser with edge detection for the asynchronous pins
`timescale 1ns/1ps
`include "sar_seq_regs.vh"

module pin_sync (
    input wire clk,
    input wire rst_n,
    input wire [3:0] pinIn,
    output wire [3:0] level,
    output wire [3:0] rise,
    output wire [3:0] fall
);
    reg [3:0] stageOne;
    reg [3:0] stageTwo;
    reg [3:0] stageOld;

    // Only stageTwo and stageOld feed logic; stageOne may be metastable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stageOne <= `SEQ_PIN_RESET;
            stageTwo <= `SEQ_PIN_RESET;
            stageOld <= `SEQ_PIN_RESET;
        end else begin
            stageOne <= pinIn;
            stageTwo <= stageOne;
            stageOld <= stageTwo;
        end
    end

    assign level = stageTwo;
    assign rise = stageTwo & ~stageOld;
    assign fall = ~stageTwo & stageOld;
endmodule // pin_sync

// ### core/sar_adc_serial_sequencer.v
// Serial frame sequencer of the 12-bit converter: framing, output, mux, power
// Functional notes
// - Word is 16 bits, MSB first: result in D15..D4, D3..D0 don't care.
// - Code 000h at or below ground, FFFh at reference minus one LSB.
// - Single variant, frame sync high at select fall: output changes on SCLK rise.
// - Combined pin: its falling edge starts a cycle, as select or as sync.
// - Dual variant: active cycle of 4 to 7 SCLKs resets mux to channel zero.
// - Dual variant: completed full cycle toggles the mux on the pin's rise.
// - Sampling lasts 12 SCLKs, starting on the fifth SCLK of the cycle.
// - Conversion starts after the 16th SCLK; takes 3.5 us plus 0.1 us.
// - Conversion runs on the internal 4 MHz clock and needs 14 of its clocks.
// - Select rising before completion aborts; next output word is invalid.
// - A result appears on the serial output during the following cycle.
// - DSP frame on select, and combined variants, change output on SCLK fall.
// - Power down at end of conversion; wake on next select or sync fall.
// - Output high impedance while the pin is high and after the 16th SCLK.
// - Sync low at select fall: MSB driven after the first of both falls.
`timescale 1ns/1ps
`include "sar_seq_regs.vh"

module sar_adc_serial_sequencer #(
    parameter [1:0] VARIANT = `SEQ_VARIANT_SINGLE
) (
    input wire clk,
    input wire rst_n,
    input wire serialClock,
    input wire chipSelectN,
    input wire frameSyncIn,
    input wire selectOrFramePin,
    input wire comparatorIn,
    output reg serialResultOut,
    output reg serialResultOe,
    output reg sampleEnable,
    output reg channelSelect,
    output reg powerDown,
    output reg resultValid,
    output wire convBusy,
    output wire [11:0] dacCode
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_FRAME = 2'h1;
    localparam [1:0] ST_CONVERT = 2'h2;
    localparam [1:0] ST_SLEEP = 2'h3;

    wire [3:0] pinLevel;
    wire [3:0] pinRise;
    wire [3:0] pinFall;
    wire [11:0] engineResult;
    wire engineDone;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [4:0] sclkCount;
    reg [15:0] shiftWord;
    reg [11:0] heldResult;
    reg heldValid;
    reg risingMode;
    reg firstRiseSeen;
    reg doneSeen;
    reg convComplete;
    reg startConv;
    reg abortConv;

    pin_sync u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn({selectOrFramePin, frameSyncIn, chipSelectN, serialClock}),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    sar_engine u_sar_engine (
        .clk(clk),
        .rst_n(rst_n),
        .convStart(startConv),
        .convAbort(abortConv),
        .comparatorIn(comparatorIn),
        .trialCode(dacCode),
        .resultBits(engineResult),
        .convBusy(convBusy),
        .convDone(engineDone)
    );

    // Pin view per variant
    wire combined = (VARIANT != `SEQ_VARIANT_SINGLE);
    wire dualMux = (VARIANT == `SEQ_VARIANT_DUAL);
    wire csLow = ~pinLevel[`SEQ_PIN_CS];
    wire fsHigh = pinLevel[`SEQ_PIN_FS];
    wire selHigh = combined ? pinLevel[`SEQ_PIN_COMB] : pinLevel[`SEQ_PIN_CS];
    wire selFall = combined ? pinFall[`SEQ_PIN_COMB] : pinFall[`SEQ_PIN_CS];
    wire selRise = combined ? pinRise[`SEQ_PIN_COMB] : pinRise[`SEQ_PIN_CS];
    wire sclkRise = pinRise[`SEQ_PIN_SCLK];
    wire sclkFall = pinFall[`SEQ_PIN_SCLK];
    wire idleLike = (state == ST_IDLE) || (state == ST_SLEEP);

    // Single variant: select fall with sync high, or sync fall while selected
    wire singleStart = (pinFall[`SEQ_PIN_CS] & fsHigh) | (pinFall[`SEQ_PIN_FS] & csLow);
    wire startEvent = idleLike && (combined ? selFall : singleStart);
    // MSB goes out on whichever comes first: select fall or cycle start
    wire loadEvent = idleLike && (selFall || startEvent);

    wire [4:0] countNext = sclkCount + 5'h01;
    wire frameEnd = (state == ST_FRAME) && sclkFall && (countNext == `SEQ_SCLK_WORD);
    wire shortCycle = (sclkCount >= `SEQ_MUX_RESET_MIN) && (sclkCount <= `SEQ_MUX_RESET_MAX);
    wire abortNow = (state == ST_CONVERT) && selRise && !doneSeen;

    function [15:0] resultWord;
        input [11:0] result;
        begin
            resultWord = {result, `SEQ_PAD_VALUE};
        end
    endfunction

    // State sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (startEvent) next_state = ST_FRAME;
            end
            ST_FRAME: begin
                if (selRise) next_state = ST_IDLE;
                else if (frameEnd) next_state = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (doneSeen) next_state = ST_SLEEP;
                else if (selRise) next_state = ST_IDLE;
            end
            ST_SLEEP: begin
                if (startEvent) next_state = ST_FRAME;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // Frame counter, sampling window and conversion launch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkCount <= 5'h00;
            sampleEnable <= 1'b0;
            startConv <= 1'b0;
            abortConv <= 1'b0;
        end else begin
            startConv <= 1'b0;
            abortConv <= abortNow;
            if (startEvent) begin
                sclkCount <= 5'h00;
                sampleEnable <= 1'b0;
            end else if (state == ST_FRAME && selRise) begin
                sampleEnable <= 1'b0;
            end else if (state == ST_FRAME && sclkFall) begin
                sclkCount <= countNext;
                // Window opens as the fifth SCLK begins and spans 12 SCLKs
                if (countNext == `SEQ_SCLK_SAMPLE_FIRST - 5'h01) begin
                    sampleEnable <= 1'b1;
                end
                if (countNext == `SEQ_SCLK_SAMPLE_FIRST - 5'h01 + `SEQ_SCLK_SAMPLE_LEN) begin
                    sampleEnable <= 1'b0;
                end
                if (countNext == `SEQ_SCLK_WORD) begin
                    startConv <= 1'b1;
                end
            end
        end
    end

    // Completion passes one register stage before anything acts on it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doneSeen <= 1'b0;
        end else begin
            doneSeen <= engineDone && (state == ST_CONVERT);
        end
    end

    // Result holding, validity and power state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heldResult <= 12'h000;
            heldValid <= 1'b0;
            convComplete <= 1'b0;
            powerDown <= 1'b1;
        end else begin
            if (startEvent) begin
                convComplete <= 1'b0;
                powerDown <= 1'b0;
            end
            if (doneSeen) begin
                heldResult <= engineResult;
                heldValid <= 1'b1;
                convComplete <= 1'b1;
                powerDown <= 1'b1;
            end else if (abortNow) begin
                // Cut-short conversion: the word of the next cycle is invalid
                heldValid <= 1'b0;
            end
        end
    end

    // Input multiplexer of the dual variant
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channelSelect <= 1'b0;
        end else if (dualMux && selRise) begin
            if (state == ST_FRAME && shortCycle) begin
                channelSelect <= 1'b0;
            end else if (convComplete || doneSeen) begin
                channelSelect <= ~channelSelect;
            end
        end
    end

    // Edge choice is latched at select fall; without one, falling-edge mode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            risingMode <= 1'b0;
        end else if (idleLike && selFall) begin
            risingMode <= !combined && fsHigh;
        end
    end

    // Serial output shifter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftWord <= 16'h0000;
            serialResultOut <= 1'b0;
            serialResultOe <= 1'b0;
            resultValid <= 1'b0;
            firstRiseSeen <= 1'b0;
        end else begin
            if (loadEvent) begin
                // Previous conversion goes out in this cycle
                shiftWord <= resultWord(heldResult);
                serialResultOut <= heldResult[11];
                serialResultOe <= 1'b1;
                resultValid <= heldValid;
                firstRiseSeen <= 1'b0;
            end else if (selHigh || frameEnd) begin
                serialResultOe <= 1'b0;
            end else if (serialResultOe) begin
                if (risingMode && sclkRise) begin
                    // The first rise keeps the MSB for the host's first falling sample
                    firstRiseSeen <= 1'b1;
                    if (firstRiseSeen) begin
                        shiftWord <= {shiftWord[14:0], 1'b0};
                        serialResultOut <= shiftWord[14];
                    end
                end else if (!risingMode && sclkFall) begin
                    shiftWord <= {shiftWord[14:0], 1'b0};
                    serialResultOut <= shiftWord[14];
                end
            end
        end
    end
endmodule // sar_adc_serial_sequencer

// ### core/sar_engine.v
// Successive-approximation engine paced by the internal conversion clock
`timescale 1ns/1ps
`include "sar_seq_regs.vh"

module sar_engine (
    input wire clk,
    input wire rst_n,
    input wire convStart,
    input wire convAbort,
    input wire comparatorIn,
    output reg [11:0] trialCode,
    output reg [11:0] resultBits,
    output reg convBusy,
    output reg convDone
);
    // Counts are worked out wide, then cut to the counter widths on purpose
    localparam integer OSC_LAST_W = `SEQ_OSC_DIV - 1;
    localparam integer STEP_LAST_W = `SEQ_CONV_OSC_CLOCKS - 1;
    localparam integer OVH_LAST_W = `SEQ_OVERHEAD_CYCLES - 1;
    localparam [4:0] OSC_LAST = OSC_LAST_W[4:0];
    localparam [3:0] STEP_LAST = STEP_LAST_W[3:0];
    localparam [3:0] OVH_LAST = OVH_LAST_W[3:0];

    reg [4:0] oscCount;
    reg [3:0] step;
    reg [3:0] overhead;
    reg inOverhead;
    reg compMeta;
    reg compSync;
    reg [11:0] trial;

    function [11:0] bitMask;
        input [3:0] idx;
        begin
            bitMask = 12'h001 << idx;
        end
    endfunction

    wire oscTick = convBusy && !inOverhead && (oscCount == OSC_LAST);
    wire [3:0] bitIdx = 4'hc - step;

    always @* begin
        trial = trialCode;
        // A high comparator means input at or above the DAC level: keep the bit
        if (!compSync) trial = trial & ~bitMask(bitIdx);
        if (bitIdx != 4'h0) trial = trial | bitMask(bitIdx - 4'h1);
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
            oscCount <= 5'h00;
            step <= 4'h0;
            overhead <= 4'h0;
            inOverhead <= 1'b0;
            trialCode <= 12'h000;
            resultBits <= 12'h000;
            convBusy <= 1'b0;
            convDone <= 1'b0;
        end else begin
            compMeta <= comparatorIn;
            compSync <= compMeta;
            convDone <= 1'b0;
            if (convAbort) begin
                convBusy <= 1'b0;
                inOverhead <= 1'b0;
            end else if (convStart) begin
                convBusy <= 1'b1;
                oscCount <= 5'h00;
                step <= 4'h0;
                inOverhead <= 1'b0;
                trialCode <= 12'h000;
            end else if (convBusy && inOverhead) begin
                overhead <= overhead + 4'h1;
                if (overhead == OVH_LAST) begin
                    convBusy <= 1'b0;
                    convDone <= 1'b1;
                end
            end else if (convBusy) begin
                oscCount <= (oscCount == OSC_LAST) ? 5'h00 : oscCount + 5'h01;
                if (oscTick) begin
                    step <= step + 4'h1;
                    if (step == 4'h0) begin
                        trialCode <= 12'h800;
                    end else if (step == STEP_LAST) begin
                        resultBits <= trialCode;
                        inOverhead <= 1'b1;
                        overhead <= 4'h0;
                    end else if (step != 4'hd) begin
                        trialCode <= trial;
                    end
                end
            end
        end
    end
endmodule // sar_engine

// ### inc/sar_seq_regs.vh
// Constants of the converter sequencer: variants, pin slots, timing counts
`ifndef SAR_SEQ_REGS_VH
`define SAR_SEQ_REGS_VH

// Device variants
`define SEQ_VARIANT_SINGLE 2'h0
`define SEQ_VARIANT_DUAL 2'h1
`define SEQ_VARIANT_PSEUDO 2'h2

// Slots of the synchronised pin vector
`define SEQ_PIN_SCLK 0
`define SEQ_PIN_CS 1
`define SEQ_PIN_FS 2
`define SEQ_PIN_COMB 3
`define SEQ_PIN_COUNT 4
`define SEQ_PIN_RESET 4'he

// Result word layout
`define SEQ_RESULT_BITS 12
`define SEQ_WORD_BITS 16
`define SEQ_PAD_VALUE 4'h0

// Serial clock counts of one frame
`define SEQ_SCLK_SAMPLE_FIRST 5'h05
`define SEQ_SCLK_SAMPLE_LEN 5'h0c
`define SEQ_SCLK_WORD 5'h10
`define SEQ_MUX_RESET_MIN 5'h04
`define SEQ_MUX_RESET_MAX 5'h07

// Conversion timing
`define SEQ_CLK_PERIOD_NS 10
`define SEQ_OSC_MIN_FREQ_MHZ 4
`define SEQ_OSC_PERIOD_NS (1000 / `SEQ_OSC_MIN_FREQ_MHZ)
`define SEQ_OSC_DIV (`SEQ_OSC_PERIOD_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_CONV_OSC_CLOCKS 14
`define SEQ_OVERHEAD_NS 100
`define SEQ_OVERHEAD_CYCLES (`SEQ_OVERHEAD_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_CYCLE_MIN_NS 4400

`endif

// ### sim/host_spi_model.sv
// Host serial port model: frames the combined pin and clocks the word in
`timescale 1ns/1ps
module host_spi_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [4:0] nClk,
    input wire logic [9:0] tailLen,
    input wire logic serialResultOut,
    input wire logic serialResultOe,
    input wire logic resultValid,
    output logic serialClock,
    output logic selectOrFramePin,
    output logic [15:0] word,
    output logic vld,
    output logic done
);
    // A released line shows the inverse so a stale bit never passes
    wire sdoWire = serialResultOe ? serialResultOut : ~serialResultOut;
    initial begin
        serialClock = 1'b0;
        selectOrFramePin = 1'b1;
        word = 16'h0000;
        vld = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                selectOrFramePin <= 1'b0;
                repeat (8) @(posedge clk);
                // Short counts of 4 to 7 clocks force the channel back to zero
                for (int i = 0; i < nClk; i++) begin
                    serialClock <= 1'b1;
                    repeat (8) @(posedge clk);
                    serialClock <= 1'b0;
                    word <= {word[14:0], sdoWire};
                    if (i == 0) vld <= resultValid;
                    repeat (8) @(posedge clk);
                end
                // A long tail keeps the cycle above its minimum; a short one aborts
                repeat (tailLen) @(posedge clk);
                selectOrFramePin <= 1'b1;
                repeat (20) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule // host_spi_model

// ### sim/sar_seq_monitor.sv
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
module sar_seq_monitor (
    input logic clk,
    input logic rst_n,
    input logic serialClock,
    input logic selectOrFramePin,
    input logic serialResultOe,
    input logic sampleEnable,
    input logic channelSelect,
    input logic powerDown,
    input logic convBusy
);
    logic sclkQ;
    logic [4:0] fallCnt;
    logic [9:0] busyCnt;
    // Counts SCLK falls of the open frame; the design sees them a clock or two later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkQ <= 1'b0;
            fallCnt <= 5'h00;
            busyCnt <= 10'h000;
        end else begin
            sclkQ <= serialClock;
            fallCnt <= selectOrFramePin ? 5'h00 : fallCnt + {4'h0, sclkQ & !serialClock};
            busyCnt <= convBusy ? busyCnt + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_drive; ##[2:5] serialResultOe; endsequence
    sequence s_convStart; ##[0:2] convBusy; endsequence
    property p_start; $fell(selectOrFramePin) && !convBusy |-> s_drive; endproperty
    a_start: assert property (p_start) else $error("output not driven after start");
    property p_wake; $fell(selectOrFramePin) && powerDown |-> ##[1:5] !powerDown; endproperty
    a_wake: assert property (p_wake) else $error("no wake on start edge");
    property p_oe_idle; selectOrFramePin [*5] |-> !serialResultOe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while pin high");
    property p_oe_end; $rose(fallCnt == 5'h10) |-> ##[1:5] !serialResultOe; endproperty
    a_oe_end: assert property (p_oe_end) else $error("output driven after last bit");
    property p_sample_start; $rose(sampleEnable) |-> fallCnt == 5'h04; endproperty
    a_sample_start: assert property (p_sample_start) else $error("sampling start off");
    property p_sample_end;
        $fell(sampleEnable) && !selectOrFramePin |-> fallCnt == 5'h10 ##0 s_convStart;
    endproperty
    a_sample_end: assert property (p_sample_end) else $error("sampling end off");
    property p_busy_len;
        $fell(convBusy) && !selectOrFramePin |-> busyCnt >= 10'h15e && busyCnt <= 10'h172;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion length off");
    property p_pd_done; $fell(convBusy) && !selectOrFramePin |-> ##[1:3] powerDown; endproperty
    a_pd_done: assert property (p_pd_done) else $error("no power-down after conversion");
    property p_abort; convBusy && $rose(selectOrFramePin) |-> ##[1:5] !convBusy; endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");
    property p_chan_toggle;
        $rose(selectOrFramePin) && powerDown |-> ##[1:6] $changed(channelSelect);
    endproperty
    a_chan_toggle: assert property (p_chan_toggle) else $error("channel not toggled");
    property p_chan_reset;
        $rose(selectOrFramePin) && fallCnt >= 5'h04 && fallCnt <= 5'h07 |-> ##[2:6] !channelSelect;
    endproperty
    a_chan_reset: assert property (p_chan_reset) else $error("channel not reset");
endmodule // sar_seq_monitor
bind sar_adc_serial_sequencer sar_seq_monitor mon (.clk(clk), .rst_n(rst_n),
    .serialClock(serialClock), .selectOrFramePin(selectOrFramePin),
    .serialResultOe(serialResultOe), .sampleEnable(sampleEnable),
    .channelSelect(channelSelect), .powerDown(powerDown), .convBusy(convBusy));

// ### sim/tb_sar_adc_serial_sequencer.sv
// Self-checking bench of the converter sequencer, dual-input variant
`timescale 1ns/1ps
module tb_sar_adc_serial_sequencer;
    typedef struct {logic [15:0] w; logic v; logic chkW; logic ch;} note_t;
    note_t q[$];
    logic clk = 1'b0, rst_n = 1'b0, comparatorIn = 1'b0, go = 1'b0;
    logic [4:0] nClk = 5'h00;
    logic [9:0] tailLen = 10'h000;
    logic [11:0] vin = 12'h000, prevRes = 12'h000;
    logic prevOk = 1'b0, chan = 1'b0;
    int errTotal = 0, checks = 0;
    wire serialClock, selectOrFramePin, serialResultOut, serialResultOe, sampleEnable;
    wire channelSelect, powerDown, resultValid, convBusy, hostVld, hostDone;
    wire [11:0] dacCode;
    wire [15:0] hostWord;
    sar_adc_serial_sequencer #(.VARIANT(2'h1)) dut (.clk(clk), .rst_n(rst_n),
        .serialClock(serialClock), .chipSelectN(1'b1), .frameSyncIn(1'b1),
        .selectOrFramePin(selectOrFramePin), .comparatorIn(comparatorIn),
        .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
        .sampleEnable(sampleEnable), .channelSelect(channelSelect), .powerDown(powerDown),
        .resultValid(resultValid), .convBusy(convBusy), .dacCode(dacCode));
    host_spi_model host (.clk(clk), .go(go), .nClk(nClk), .tailLen(tailLen),
        .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
        .resultValid(resultValid), .serialClock(serialClock),
        .selectOrFramePin(selectOrFramePin), .word(hostWord), .vld(hostVld), .done(hostDone));
    initial begin
        forever #5 clk = ~clk;
    end
    // Ideal comparator: the analog input against the trial code
    always @(posedge clk) comparatorIn <= (vin >= dacCode);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (errTotal == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic frame(input logic [11:0] v, input int n, input int tail, input logic chk);
        note_t e;
        e.w = {prevRes, 4'h0};
        e.v = prevOk;
        e.chkW = chk;
        vin <= v;
        if (n == 16 && tail >= 300) begin
            prevRes = v;
            prevOk = 1'b1;
            chan = ~chan;
        end else if (n == 16) begin
            prevOk = 1'b0;
        end else begin
            chan = 1'b0;
            prevOk = 1'b0;
        end
        e.ch = chan;
        q.push_back(e);
        nClk <= n[4:0];
        tailLen <= tail[9:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (hostDone !== 1'b1);
    endtask
    always @(posedge clk) begin
        if (hostDone === 1'b1) begin
            note_t e;
            e = q.pop_front();
            check({15'h0000, channelSelect}, {15'h0000, e.ch});
            if (e.chkW) check({15'h0000, hostVld}, {15'h0000, e.v});
            if (e.chkW && e.v) check(hostWord, e.w);
        end
    end
    initial begin
        #200000;
        errTotal++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h2b7516d4));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        frame(12'h000, 16, 420, 1'b1);
        frame(12'hfff, 16, 420, 1'b1);
        repeat (4) frame($urandom() & 12'hfff, 16, 420, 1'b1);
        frame(12'h5a5, 16, 420, 1'b1);
        frame(12'h3c3, 16, 20, 1'b1);
        frame(12'h7e1, 16, 420, 1'b1);
        for (int n = 4; n <= 7; n++) begin
            frame(12'h000, 16, 420, 1'b0);
            frame(12'h000, n, 20, 1'b0);
        end
        frame($urandom() & 12'hfff, 16, 420, 1'b0);
        frame($urandom() & 12'hfff, 16, 420, 1'b1);
        tally_and_finish();
    end
endmodule // tb_sar_adc_serial_sequencer
